// ### nsri_top.sv
`default_nettype none
module nsri_top #(
   parameter int unsigned MS_CYCLES = nsri_pkg::MS_CYCLES
) (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic lte_registered,
   input wire logic net_searching,
   input wire logic net_idle,
   input wire logic data_active,
   input wire logic voice_active,
   input wire logic [2:0] notify_issue,
   input wire logic [1:0] notification_port_select,
   input wire logic [1:0] ring_behaviour_config,
   output logic lte_registered_indicator,
   output logic network_activity_indicator,
   output logic ring_indicator_out,
   output logic [1:0] notify_port_active
);
   timeunit 1ns;
   timeprecision 1ns;
   // Millisecond tick divider.
   logic [31:0] div_q;
   logic tick_q;
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         div_q <= 32'h0000_0000;
         tick_q <= 1'b0;
      end
      else
      begin
         tick_q <= (div_q == MS_CYCLES - 1);
         div_q <= (div_q == MS_CYCLES - 1) ? 32'h0000_0000 : div_q + 32'h0000_0001;
      end
   end

   // Activity mode selection by priority.
   nsri_pkg::nsri_act_type mode_d, mode_q;
   assign mode_d = voice_active ? nsri_pkg::ACT_VOICE :
                   data_active ? nsri_pkg::ACT_DATA :
                   net_idle ? nsri_pkg::ACT_IDLE :
                   net_searching ? nsri_pkg::ACT_SEARCH : nsri_pkg::ACT_OFF;
   wire mode_chg = (mode_d != mode_q);

   // Phase lengths of the current pattern; first phase is listed first.
   logic [11:0] ph0_len, ph1_len;
   logic ph0_lvl;
   always_comb
   begin
      case (mode_q)
         nsri_pkg::ACT_SEARCH:
         begin
            ph0_len = 12'(nsri_pkg::SEARCH_HI_MS);
            ph1_len = 12'(nsri_pkg::SEARCH_LO_MS);
            ph0_lvl = 1'b1;
         end
         nsri_pkg::ACT_IDLE:
         begin
            ph0_len = 12'(nsri_pkg::IDLE_HI_MS);
            ph1_len = 12'(nsri_pkg::IDLE_LO_MS);
            ph0_lvl = 1'b1;
         end
         nsri_pkg::ACT_DATA:
         begin
            ph0_len = 12'(nsri_pkg::DATA_LO_MS);
            ph1_len = 12'(nsri_pkg::DATA_HI_MS);
            ph0_lvl = 1'b0;
         end
         default:
         begin
            ph0_len = 12'h001;
            ph1_len = 12'h001;
            ph0_lvl = 1'b0;
         end
      endcase
   end

   // Blink pattern generator.
   logic [11:0] ph_cnt_q;
   logic ph_q;
   wire [11:0] cur_len = ph_q ? ph1_len : ph0_len;
   wire ph_end = tick_q && (ph_cnt_q == cur_len - 12'h001);
   wire blink_lvl = ph_q ? ~ph0_lvl : ph0_lvl;
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         mode_q <= nsri_pkg::ACT_OFF;
         ph_cnt_q <= 12'h000;
         ph_q <= 1'b0;
      end
      else if (mode_chg)
      begin
         mode_q <= mode_d;
         ph_cnt_q <= 12'h000;
         ph_q <= 1'b0;
      end
      else if (ph_end)
      begin
         ph_cnt_q <= 12'h000;
         ph_q <= ~ph_q;
      end
      else if (tick_q)
         ph_cnt_q <= ph_cnt_q + 12'h001;
   end

   // Indicator outputs, registered.
   wire act_lvl = (mode_q == nsri_pkg::ACT_VOICE) ? 1'b1 :
                  (mode_q == nsri_pkg::ACT_OFF) ? 1'b0 : blink_lvl;
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         lte_registered_indicator <= 1'b0;
         network_activity_indicator <= 1'b0;
      end
      else
      begin
         lte_registered_indicator <= lte_registered;
         network_activity_indicator <= act_lvl;
      end
   end

   // Notification port register; power-up default is the USB command port.
   logic [1:0] port_q;
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
         port_q <= nsri_pkg::PORT_USB_CMD;
      else if (notification_port_select <= nsri_pkg::PORT_USB_MODEM)
         port_q <= notification_port_select;
   end
   assign notify_port_active = port_q;

   // Any notification on any port requests a ring pulse.
   wire notify_any = |notify_issue;

   // Ring indicator sequencer with power-up phase.
   nsri_pkg::nsri_ri_type ri_q;
   logic [11:0] ri_cnt_q;
   logic ri_out_q;
   wire [11:0] ri_len = (ri_q == nsri_pkg::RI_BOOT_HI) ? 12'(nsri_pkg::BOOT_HI_MS) :
                        (ri_q == nsri_pkg::RI_BOOT_LO) ? 12'(nsri_pkg::BOOT_LO_MS) :
                        12'(nsri_pkg::RING_PULSE_MS);
   wire ri_done = tick_q && (ri_cnt_q == ri_len - 12'h001);
   wire cfg_pulse = (ring_behaviour_config == nsri_pkg::RING_CFG_PULSE);
   wire cfg_low = (ring_behaviour_config == nsri_pkg::RING_CFG_ALWAYS_LOW);
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         ri_q <= nsri_pkg::RI_BOOT_HI;
         ri_cnt_q <= 12'h000;
         ri_out_q <= 1'b1;
      end
      else
      begin
         case (ri_q)
            nsri_pkg::RI_BOOT_HI, nsri_pkg::RI_BOOT_LO:
            begin
               ri_out_q <= (ri_q == nsri_pkg::RI_BOOT_HI);
               if (ri_done)
               begin
                  ri_cnt_q <= 12'h000;
                  ri_q <= (ri_q == nsri_pkg::RI_BOOT_HI) ? nsri_pkg::RI_BOOT_LO : nsri_pkg::RI_IDLE;
                  ri_out_q <= (ri_q == nsri_pkg::RI_BOOT_LO) ? ~cfg_low : 1'b0;
               end
               else if (tick_q)
                  ri_cnt_q <= ri_cnt_q + 12'h001;
            end
            nsri_pkg::RI_IDLE:
            begin
               ri_cnt_q <= 12'h000;
               ri_out_q <= ~cfg_low;
               if (notify_any && cfg_pulse)
               begin
                  ri_q <= nsri_pkg::RI_PULSE;
                  ri_out_q <= 1'b0;
               end
            end
            nsri_pkg::RI_PULSE:
            begin
               ri_out_q <= 1'b0;
               if (ri_done)
               begin
                  ri_q <= nsri_pkg::RI_IDLE;
                  ri_cnt_q <= 12'h000;
                  ri_out_q <= ~cfg_low;
               end
               else if (tick_q)
                  ri_cnt_q <= ri_cnt_q + 12'h001;
            end
            default:
               ri_q <= nsri_pkg::RI_IDLE;
         endcase
      end
   end
   assign ring_indicator_out = ri_out_q;

   // Checks on the indicator behaviour.
   chk_lte_follow: assert property (@(posedge clk_sys) disable iff (!rstn)
      ##1 lte_registered_indicator == $past(lte_registered))
      else $error("LTE indicator does not follow registration");
   chk_voice_high: assert property (@(posedge clk_sys) disable iff (!rstn)
      (mode_q == nsri_pkg::ACT_VOICE) |=> network_activity_indicator)
      else $error("Activity indicator low during voice call");
   chk_off_low: assert property (@(posedge clk_sys) disable iff (!rstn)
      (mode_q == nsri_pkg::ACT_OFF) |=> !network_activity_indicator)
      else $error("Activity indicator high with no network");
   chk_voice_prio: assert property (@(posedge clk_sys) disable iff (!rstn)
      voice_active |=> mode_q == nsri_pkg::ACT_VOICE)
      else $error("Voice call not given priority");
   chk_restart_phase: assert property (@(posedge clk_sys) disable iff (!rstn)
      mode_chg |=> (ph_cnt_q == 12'h000) && !ph_q)
      else $error("Pattern change did not restart phase");
   chk_tick_period: assert property (@(posedge clk_sys) disable iff (!rstn)
      tick_q |=> !tick_q [*2])
      else $error("Millisecond tick too frequent");
   chk_ring_start: assert property (@(posedge clk_sys) disable iff (!rstn)
      (ri_q == nsri_pkg::RI_IDLE && notify_any && cfg_pulse) |=> !ring_indicator_out && ri_q == nsri_pkg::RI_PULSE)
      else $error("Notification did not start ring pulse");
   chk_ring_idle: assert property (@(posedge clk_sys) disable iff (!rstn)
      (ri_q == nsri_pkg::RI_IDLE && !notify_any && cfg_pulse) |=> ring_indicator_out)
      else $error("Ring indicator not high while idle");
   chk_ring_len: assert property (@(posedge clk_sys) disable iff (!rstn)
      (ri_q == nsri_pkg::RI_PULSE) |-> ri_cnt_q < 12'(nsri_pkg::RING_PULSE_MS))
      else $error("Ring pulse overran its length");
   chk_boot_high: assert property (@(posedge clk_sys) disable iff (!rstn)
      (ri_q == nsri_pkg::RI_BOOT_HI && !ri_done) |=> ring_indicator_out)
      else $error("Ring pin not high in first power-up phase");
   chk_port_default: assert property (@(posedge clk_sys)
      !rstn |=> port_q == nsri_pkg::PORT_USB_CMD || rstn)
      else $error("Notification port default wrong");
   cov_voice: cover property (@(posedge clk_sys) disable iff (!rstn) mode_q == nsri_pkg::ACT_VOICE);
   cov_data_toggle: cover property (@(posedge clk_sys) disable iff (!rstn) mode_q == nsri_pkg::ACT_DATA && ph_end);
   cov_ring_pulse: cover property (@(posedge clk_sys) disable iff (!rstn) ri_q == nsri_pkg::RI_PULSE && ri_done);
endmodule : nsri_top
`default_nettype wire

// ### nsri_pkg.sv
// Overview of operation
// - LTE indicator high while registered on LTE, low otherwise.
// - Searching: activity indicator high 200 ms, low 1800 ms, repeating.
// - Registered idle: activity indicator high 234 ms, low 266 ms, repeating.
// - Data transfer: activity indicator low 63 ms, high 62 ms, repeating.
// - Voice call: activity indicator held steadily high.
// - Ring indicator rests high when no notification is pending, except in the always-low configuration, where it rests low.
// - Each new notification drives one 120 ms low ring pulse by default.
// - Notifications on any port trigger the ring pulse.
// - Ring behaviour is configurable; default idle-high low-pulse until changed.
// - Notification port selectable among three ports; defaults to USB command port.
// - After power-on ring pin is high 2 s, then low 1.2 s, then normal.
`default_nettype none
package nsri_pkg;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int unsigned CLK_HZ = 50_000_000;
   localparam int unsigned MS_CYCLES = CLK_HZ / 1000;
   localparam int unsigned SEARCH_HI_MS = 200;
   localparam int unsigned SEARCH_LO_MS = 1800;
   localparam int unsigned IDLE_HI_MS = 234;
   localparam int unsigned IDLE_LO_MS = 266;
   localparam int unsigned DATA_LO_MS = 63;
   localparam int unsigned DATA_HI_MS = 62;
   localparam int unsigned RING_PULSE_MS = 120;
   localparam int unsigned BOOT_HI_MS = 2000;
   localparam int unsigned BOOT_LO_MS = 1200;
   localparam logic [1:0] PORT_MAIN_UART = 2'h0;
   localparam logic [1:0] PORT_USB_CMD = 2'h1;
   localparam logic [1:0] PORT_USB_MODEM = 2'h2;
   localparam logic [1:0] RING_CFG_PULSE = 2'h0;
   localparam logic [1:0] RING_CFG_OFF = 2'h1;
   localparam logic [1:0] RING_CFG_ALWAYS_LOW = 2'h2;
   typedef enum logic [2:0] {ACT_OFF, ACT_SEARCH, ACT_IDLE, ACT_DATA, ACT_VOICE} nsri_act_type;
   typedef enum logic [1:0] {RI_BOOT_HI, RI_BOOT_LO, RI_IDLE, RI_PULSE} nsri_ri_type;
endpackage : nsri_pkg
`default_nettype wire

// ### nsri_host_model.sv
`default_nettype none
// Host ring input: measures each low stretch of the ring line in clock cycles.
module nsri_host_model (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic ring_indicator_out,
   output int low_len,
   output int pulse_cnt
);
   timeunit 1ns;
   timeprecision 1ns;
   int run_q;
   logic boot_seen_q;
   // The first low stretch after power-up is the 1.2 s boot low phase of the ring sequencer, so it is not counted.
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         run_q <= 0;
         boot_seen_q <= 1'b0;
         low_len <= 0;
         pulse_cnt <= 0;
      end
      else if (ring_indicator_out !== 1'b1)
         run_q <= run_q + 1;
      else if (run_q != 0)
      begin
         run_q <= 0;
         boot_seen_q <= 1'b1;
         if (boot_seen_q)
         begin
            low_len <= run_q;
            pulse_cnt <= pulse_cnt + 1;
         end
      end
   end
endmodule // nsri_host_model
`default_nettype wire

// ### nsri_top_test.sv
`default_nettype none
module nsri_top_test;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int MS = 10;
   logic clk_sys = 1'b0;
   logic rstn = 1'b0;
   logic lte = 1'b0, srch = 1'b0, idle = 1'b0, data = 1'b0, voice = 1'b0;
   logic [2:0] notify = 3'h0;
   logic [1:0] psel = 2'h1;
   logic [1:0] rcfg = 2'h0;
   logic lte_ind, act, ring;
   logic [1:0] port;
   int low_len, pulse_cnt, n;
   int error_cnt = 0;
   int n_tests = 0;
   int cyc = 0;
   logic [1:0] pexp = 2'h1;
   nsri_top #(.MS_CYCLES(MS)) i_nsri_top (.clk_sys(clk_sys), .rstn(rstn), .lte_registered(lte),
      .net_searching(srch), .net_idle(idle), .data_active(data), .voice_active(voice), .notify_issue(notify),
      .notification_port_select(psel), .ring_behaviour_config(rcfg), .lte_registered_indicator(lte_ind),
      .network_activity_indicator(act), .ring_indicator_out(ring), .notify_port_active(port));
   nsri_host_model i_nsri_host_model (.clk_sys(clk_sys), .rstn(rstn), .ring_indicator_out(ring),
      .low_len(low_len), .pulse_cnt(pulse_cnt));
   // Free-running 50 MHz clock.
   initial
   begin
      forever #10 clk_sys = ~clk_sys;
   end
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // Cuts a hung run short.
   always @(posedge clk_sys)
   begin
      cyc <= cyc + 1;
      if (cyc == 95000)
      begin
         error_cnt++;
         tally_and_finish();
      end
   end
   task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("[FAIL] %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask
   // Works out which port the block should report once a select value has been offered; code 3 is ignored.
   function automatic logic [1:0] port_after(logic [1:0] prev, logic [1:0] sel);
      return (sel <= 2'h2) ? sel : prev;
   endfunction
   // Steps k edges, then lands just after the edge where outputs are settled and inputs may move.
   task automatic tick(int k);
      repeat (k) @(posedge clk_sys);
      #2;
   endtask
   task automatic ping(logic [2:0] v);
      notify = v;
      tick(1);
      notify = 3'h0;
   endtask
   task automatic span(logic lvl, output int k);
      k = 0;
      while (act === lvl && k < 30000)
      begin
         tick(1);
         k++;
      end
   endtask
   // Skips the possibly short first phase, then measures one full high and one full low phase.
   task automatic blink(string nm, int hi, int lo, logic first);
      int a, b;
      logic lvl;
      tick(3);
      chk(nm, act, first);
      span(act, a);
      lvl = act;
      span(lvl, a);
      span(~lvl, b);
      chk(nm, lvl ? a : b, hi * MS);
      chk(nm, lvl ? b : a, lo * MS);
   endtask
   // Main sequence.
   initial
   begin
      n = $urandom(12);
      tick(12);
      chk("lte rst", lte_ind, 1'b0);
      chk("act rst", act, 1'b0);
      chk("ring rst", ring, 1'b1);
      chk("port rst", port, 2'h1);
      rstn = 1'b1;
      tick(1000 * MS);
      chk("boot hi", ring, 1'b1);
      ping(3'h2);
      tick(1400 * MS);
      chk("boot lo", ring, 1'b0);
      tick(900 * MS);
      chk("boot end", ring, 1'b1);
      chk("boot cnt", pulse_cnt, 0);
      for (int i = 0; i < 3; i++)
      begin
         psel = 2'($urandom_range(3));
         pexp = port_after(pexp, psel);
         ping(3'(1 << i));
         chk("ring lo", ring, 1'b0);
         chk("port", port, pexp);
         psel = 2'h3;
         pexp = port_after(pexp, psel);
         tick(50 * MS);
         chk("port keep", port, pexp);
         ping(3'h7);
         tick(90 * MS);
         chk("ring width", low_len >= 119 * MS && low_len <= 121 * MS, 1'b1);
         chk("ring cnt", pulse_cnt, i + 1);
      end
      rcfg = 2'h1;
      ping(3'h4);
      tick(200 * MS);
      chk("ring off", pulse_cnt, 3);
      rcfg = 2'h2;
      tick(3);
      chk("ring held", ring, 1'b0);
      rcfg = 2'h0;
      tick(3);
      chk("ring back", ring, 1'b1);
      repeat (20)
      begin
         lte = 1'($urandom);
         tick(1);
         chk("lte", lte_ind, lte);
      end
      srch = 1'b1;
      blink("search", 200, 1800, 1'b1);
      idle = 1'b1;
      blink("idle", 234, 266, 1'b1);
      data = 1'b1;
      blink("data", 62, 63, 1'b0);
      voice = 1'b1;
      tick(3);
      n = 0;
      repeat (3000)
      begin
         tick(1);
         n += (act !== 1'b1);
      end
      chk("voice", n, 0);
      {srch, idle, data, voice} = 4'h0;
      tick(3);
      chk("act none", act, 1'b0);
      tally_and_finish();
   end
endmodule // nsri_top_test
`default_nettype wire
